// ===== core/btc_top.sv
// Bus trigger comparator with Wishbone registers and capture FIFO
`default_nettype none
module btc_top
    import btc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Watched processor bus, same clock
    input wire logic bus_valid_i,
    input wire logic [AW-1:0] bus_addr_i,
    input wire logic [DW-1:0] bus_data_i,
    input wire logic bus_rw_i,
    // Event outputs
    output logic trigger_o,
    output logic brk_req_o,
    output logic tag_req_o
);
    localparam int PW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Register state, one word of flops
    typedef struct packed {
        // Register bus answer
        logic [31:0] dat;
        logic ack;
        // Control fields set by software
        logic arm;
        logic rwv;
        logic rwen;
        logic breakpoint_request_enable;
        logic tag;
        logic [CTRL_MODE_W-1:0] mode;
        // Comparator values
        logic [AW-1:0] cmpa;
        logic [AW-1:0] cmpb;
        // Run progress
        logic aseen;
        logic trig_seen;
        // One-cycle event pulses
        logic trig;
        logic brk;
        logic tagr;
    } btc_top_s;

    btc_top_s st_reg;
    btc_top_s st_next;

    ////////////////////////////////////////////////////////////////////////
    // Combinational terms
    logic a_eq;
    logic b_eq;
    logic d_eq;
    logic ge_a;
    logic le_b;
    logic a_match;

    logic hit;
    logic cap;
    logic rw_ok;
    logic store_mode;
    logic full_mode;
    logic eval;
    logic brk_fire;
    logic tag_fire;
    logic fills_now;

    logic f_full;
    logic f_empty;
    logic f_rd;
    logic f_clr;
    logic [DW-1:0] f_data;
    logic [PW:0] f_cnt;

    logic req;
    logic wr;
    logic rd;
    logic ctl_sel;
    logic fifo_sel;
    logic [31:0] wmask;

    ////////////////////////////////////////////////////////////////////////
    // Comparator pair and capture store
    btc_cmp #(
        .AW(AW),
        .DW(DW)
    ) u_cmp (
        .addr_i(bus_addr_i),
        .data_i(bus_data_i),
        .cmpa_i(st_reg.cmpa),
        .cmpb_i(st_reg.cmpb),
        .a_eq_o(a_eq),
        .b_eq_o(b_eq),
        .d_eq_o(d_eq),
        .ge_a_o(ge_a),
        .le_b_o(le_b)
    );

    btc_fifo #(
        .DW(DW),
        .DEPTH(DEPTH),
        .PW(PW)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(f_clr),
        .wr_i(cap),
        .wdata_i(bus_data_i),
        .rd_i(f_rd),
        .rdata_o(f_data),
        .full_o(f_full),
        .empty_o(f_empty),
        .count_o(f_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes and register words
    function automatic logic [31:0] sel_mask(input logic [3:0] sel);
        sel_mask = '0;
        for (int i = 0; i < 4; i++) begin
            sel_mask[8*i +: 8] = {8{sel[i]}};
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    function automatic logic [31:0] status_word(input logic armed,
                                                input logic seen,
                                                input logic full,
                                                input logic empty,
                                                input logic trig,
                                                input logic [PW:0] cnt);
        status_word = RST_WORD;
        status_word[STAT_ARMED] = armed;
        status_word[STAT_ASEEN] = seen;
        status_word[STAT_FULL] = full;
        status_word[STAT_EMPTY] = empty;
        status_word[STAT_TRIG] = trig;
        status_word[STAT_CNT_LO +: PW+1] = cnt;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign wmask = sel_mask(wb_sel_i);
    assign ctl_sel = (wb_adr_i == OFS_CTRL);
    assign fifo_sel = (wb_adr_i == OFS_FIFO);
    // Reading the FIFO word pops one entry
    assign f_rd = rd && fifo_sel && wb_sel_i[0];
    // Arming a run starts a fresh capture
    assign f_clr = wr && ctl_sel && wb_sel_i[0]
                   && wb_dat_i[CTRL_ARM] && !st_reg.arm;

    ////////////////////////////////////////////////////////////////////////
    // Trigger evaluation
    assign eval = st_reg.arm && bus_valid_i;
    assign rw_ok = !st_reg.rwen || (bus_rw_i == st_reg.rwv);
    assign store_mode = (st_reg.mode == MODE_EVT_B) ||
                        (st_reg.mode == MODE_A_THEN_EVT_B);
    assign full_mode = (st_reg.mode == MODE_A_AND_D) ||
                       (st_reg.mode == MODE_A_NOT_D);

    always_comb begin
        hit = 1'b0;
        case (st_reg.mode)
            MODE_A_ONLY: begin
                hit = a_eq;
            end
            MODE_A_OR_B: begin
                hit = a_eq || b_eq;
            end
            MODE_A_THEN_B: begin
                hit = b_eq && st_reg.aseen;
            end
            MODE_EVT_B: begin
                hit = b_eq;
            end
            MODE_A_THEN_EVT_B: begin
                hit = b_eq && st_reg.aseen;
            end
            MODE_A_AND_D: begin
                hit = a_eq && d_eq && rw_ok;
            end
            MODE_A_NOT_D: begin
                hit = a_eq && !d_eq && rw_ok;
            end
            MODE_IN_RANGE: begin
                hit = ge_a && le_b;
            end
            MODE_OUT_RANGE: begin
                hit = !ge_a || !le_b;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        hit = hit && eval;
    end

    // Capture only in store modes, never past full
    assign cap = hit && store_mode && !f_full;

    ////////////////////////////////////////////////////////////////////////
    // Event requests and run control
    assign a_match = eval && a_eq;
    // Plain breakpoint: a trigger with requests on and tag off
    assign brk_fire = st_reg.breakpoint_request_enable && !st_reg.tag && hit;
    // Tag request in full modes needs only the A address
    assign tag_fire = st_reg.breakpoint_request_enable && st_reg.tag &&
                      (full_mode ? a_match : hit);
    // This capture takes the last free slot
    assign fills_now = cap && (f_cnt == (PW+1)'(DEPTH - 1));

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.ack = req;
        st_next.trig = hit;
        st_next.brk = brk_fire;
        st_next.tagr = tag_fire;

        if (hit) begin
            st_next.trig_seen = 1'b1;
        end

        if (a_match) begin
            st_next.aseen = 1'b1;
        end

        // Run stops once the FIFO cannot take more
        if (st_reg.arm && store_mode && (f_full || fills_now)) begin
            st_next.arm = 1'b0;
        end

        // Register read mux, zero outside the answer cycle
        st_next.dat = RST_WORD;
        if (rd) begin
            case (wb_adr_i)
                OFS_CTRL: begin
                    st_next.dat[CTRL_ARM] = st_reg.arm;
                    st_next.dat[CTRL_RWV] = st_reg.rwv;
                    st_next.dat[CTRL_RWEN] = st_reg.rwen;
                    st_next.dat[CTRL_BREAKPOINT_REQUEST_ENABLE] = st_reg.breakpoint_request_enable;
                    st_next.dat[CTRL_TAG] = st_reg.tag;
                    st_next.dat[CTRL_MODE_LO +: CTRL_MODE_W] = st_reg.mode;
                end
                OFS_CMPA: begin
                    st_next.dat[AW-1:0] = st_reg.cmpa;
                end
                OFS_CMPB: begin
                    st_next.dat[AW-1:0] = st_reg.cmpb;
                end
                OFS_STAT: begin
                    st_next.dat = status_word(st_reg.arm, st_reg.aseen,
                                              f_full, f_empty,
                                              st_reg.trig_seen, f_cnt);
                end
                OFS_FIFO: begin
                    st_next.dat[DW-1:0] = f_data;
                end
                default: begin
                    st_next.dat = RST_WORD;
                end
            endcase
        end

        // Register writes; a write of arm beats the auto-stop
        if (wr) begin
            case (wb_adr_i)
                OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        st_next.arm = wb_dat_i[CTRL_ARM];
                        st_next.rwv = wb_dat_i[CTRL_RWV];
                        st_next.rwen = wb_dat_i[CTRL_RWEN];
                        st_next.breakpoint_request_enable = wb_dat_i[CTRL_BREAKPOINT_REQUEST_ENABLE];
                        st_next.tag = wb_dat_i[CTRL_TAG];
                    end
                    if (wb_sel_i[1]) begin
                        st_next.mode =
                            wb_dat_i[CTRL_MODE_LO +: CTRL_MODE_W];
                    end
                    // A fresh arm forgets any earlier A match
                    if (f_clr) begin
                        st_next.aseen = 1'b0;
                        st_next.trig_seen = 1'b0;
                    end
                end
                OFS_CMPA: begin
                    st_next.cmpa = AW'(merge(32'(st_reg.cmpa), wb_dat_i,
                                             wmask));
                end
                OFS_CMPB: begin
                    st_next.cmpb = AW'(merge(32'(st_reg.cmpb), wb_dat_i,
                                             wmask));
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.mode <= RST_MODE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state flops
    assign wb_dat_o = st_reg.dat;
    assign wb_ack_o = st_reg.ack;
    assign trigger_o = st_reg.trig;
    assign brk_req_o = st_reg.brk;
    assign tag_req_o = st_reg.tagr;
endmodule
`default_nettype wire

// ===== inc/btc_pkg.sv
// Package of constants for the bus trigger comparator
`default_nettype none
package btc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;

    // Register word byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMPA = 8'h04;
    localparam logic [7:0] OFS_CMPB = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_FIFO = 8'h10;

    // Control field positions
    localparam int CTRL_ARM = 0;
    localparam int CTRL_RWV = 1;
    localparam int CTRL_RWEN = 2;
    localparam int CTRL_BREAKPOINT_REQUEST_ENABLE = 3;
    localparam int CTRL_TAG = 4;
    localparam int CTRL_MODE_LO = 8;
    localparam int CTRL_MODE_W = 4;

    // Status field positions
    localparam int STAT_ARMED = 0;
    localparam int STAT_ASEEN = 1;
    localparam int STAT_FULL = 2;
    localparam int STAT_EMPTY = 3;
    localparam int STAT_TRIG = 4;
    localparam int STAT_CNT_LO = 8;

    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_D = 4'h5;
    localparam logic [3:0] MODE_A_NOT_D = 4'h6;
    localparam logic [3:0] MODE_IN_RANGE = 4'h7;
    localparam logic [3:0] MODE_OUT_RANGE = 4'h8;

    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== core/btc_cmp.sv
// Comparator pair producing address and data match terms
`default_nettype none
module btc_cmp
    import btc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] data_i,
    input wire logic [AW-1:0] cmpa_i,
    input wire logic [AW-1:0] cmpb_i,
    output logic a_eq_o,
    output logic b_eq_o,
    output logic d_eq_o,
    output logic ge_a_o,
    output logic le_b_o
);
    assign a_eq_o = (addr_i == cmpa_i);
    assign b_eq_o = (addr_i == cmpb_i);
    // Only the low byte of B is a data value
    assign d_eq_o = (data_i == cmpb_i[DW-1:0]);
    assign ge_a_o = (addr_i >= cmpa_i);
    assign le_b_o = (addr_i <= cmpb_i);
endmodule
`default_nettype wire

// ===== core/btc_fifo.sv
// Capture FIFO for stored bus data
`default_nettype none
module btc_fifo
    import btc_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int PW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic wr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic rd_i,
    output logic [DW-1:0] rdata_o,
    output logic full_o,
    output logic empty_o,
    output logic [PW:0] count_o
);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } btc_fifo_s;
    btc_fifo_s st_reg;
    btc_fifo_s st_next;
    logic [DW-1:0] mem [DEPTH];
    logic do_wr;
    logic do_rd;

    assign full_o = (st_reg.cnt == (PW+1)'(DEPTH));
    assign empty_o = (st_reg.cnt == '0);
    assign count_o = st_reg.cnt;
    assign rdata_o = mem[st_reg.rp];
    assign do_wr = wr_i && !full_o;
    assign do_rd = rd_i && !empty_o;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        st_next = st_reg;
        if (do_wr) begin
            st_next.wp = bump(st_reg.wp);
        end
        if (do_rd) begin
            st_next.rp = bump(st_reg.rp);
        end
        if (do_wr && !do_rd) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        if (clr_i) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (do_wr && !clr_i) begin
            mem[st_reg.wp] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// ===== sim/btc_top_monitor.sv
// Checker of trigger timing at the comparator's top ports
`default_nettype none
module btc_top_monitor
    import btc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic bus_valid_i,
    input wire logic [AW-1:0] bus_addr_i,
    input wire logic [DW-1:0] bus_data_i,
    input wire logic bus_rw_i,
    input wire logic trigger_o,
    input wire logic tag_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////
    // Shadow of the set-up; blind to the store modes' own disarm
    logic [31:0] ctl_reg;
    logic [AW-1:0] ca_reg;
    logic [AW-1:0] cb_reg;
    logic seen_reg;
    logic wr, arm, aq, bq, d_eq, rw_ok, full_m;
    logic [3:0] mode;
    assign wr = wb_stb_i && wb_we_i && !wb_ack_o;
    assign arm = ctl_reg[CTRL_ARM];
    assign mode = ctl_reg[CTRL_MODE_LO+:CTRL_MODE_W];
    assign aq = bus_addr_i == ca_reg;
    assign bq = bus_addr_i == cb_reg;
    assign d_eq = bus_data_i == cb_reg[DW-1:0];
    assign rw_ok = !ctl_reg[CTRL_RWEN] || bus_rw_i == ctl_reg[CTRL_RWV];
    assign full_m = mode == MODE_A_AND_D || mode == MODE_A_NOT_D;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= RST_WORD;
            ca_reg <= '0;
            cb_reg <= '0;
            seen_reg <= 1'b0;
        end else begin
            if (wr && wb_adr_i == OFS_CTRL) begin
                ctl_reg <= wb_dat_i;
            end
            if (wr && wb_adr_i == OFS_CMPA) begin
                ca_reg <= wb_dat_i[AW-1:0];
            end
            if (wr && wb_adr_i == OFS_CMPB) begin
                cb_reg <= wb_dat_i[AW-1:0];
            end
            if (wr && wb_adr_i == OFS_CTRL && wb_dat_i[CTRL_ARM] && !arm) begin
                seen_reg <= 1'b0;
            end else if (arm && bus_valid_i && aq) begin
                seen_reg <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence watch_s;
        arm && bus_valid_i;
    endsequence
    sequence a_hit_s;
        watch_s ##0 aq;
    endsequence
    property fire_p(c);
        watch_s ##0 c |=> trigger_o;
    endproperty
    a_only_a:
        assert property (fire_p(mode == MODE_A_ONLY && aq))
            else $error("a-only match missed");
    a_or_b_a:
        assert property (fire_p(mode == MODE_A_OR_B && (aq || bq)))
            else $error("either match missed");
    b_after_a_a:
        assert property (fire_p(mode == MODE_A_THEN_B && seen_reg && bq))
            else $error("b after a missed");
    full_data_a:
        assert property (fire_p(mode == MODE_A_AND_D && aq && d_eq && rw_ok))
            else $error("full data match missed");
    full_not_a:
        assert property (fire_p(mode == MODE_A_NOT_D && aq && !d_eq && rw_ok))
            else $error("full not data match missed");
    tag_full_a:
        assert property (a_hit_s ##0 full_m && ctl_reg[CTRL_BREAKPOINT_REQUEST_ENABLE]
                         && ctl_reg[CTRL_TAG] |=> tag_req_o)
            else $error("tag request missed");
    in_range_a:
        assert property (fire_p(mode == MODE_IN_RANGE && bus_addr_i >= ca_reg
                                && bus_addr_i <= cb_reg))
            else $error("inside range missed");
    out_range_a:
        assert property (fire_p(mode == MODE_OUT_RANGE && (bus_addr_i < ca_reg
                                || bus_addr_i > cb_reg)))
            else $error("outside range missed");
    idle_quiet_a:
        assert property (!(arm && bus_valid_i) |=> !trigger_o)
            else $error("trigger while idle");
endmodule
bind btc_top btc_top_monitor #(.AW(AW), .DW(DW)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .bus_valid_i(bus_valid_i), .bus_addr_i(bus_addr_i),
    .bus_data_i(bus_data_i), .bus_rw_i(bus_rw_i), .trigger_o(trigger_o),
    .tag_req_o(tag_req_o));
`default_nettype wire

// ===== sim/btc_cpu_model.sv
// Behavioural processor bus driving the watched bus
`default_nettype none
module btc_cpu_model
    import btc_pkg::*;
(
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic rw_i,
    input wire logic brk_req_i,
    input wire logic tag_req_i,
    output var logic bus_valid_o,
    output var logic [ADDR_W-1:0] bus_addr_o,
    output var logic [DATA_W-1:0] bus_data_o,
    output var logic bus_rw_o,
    output var logic [7:0] n_brk_o,
    output var logic [7:0] n_tag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bus_valid_o = 1'b0;
        bus_addr_o = '0;
        bus_data_o = '0;
        bus_rw_o = 1'b0;
        n_brk_o = 8'h00;
        n_tag_o = 8'h00;
    end
    // Idle cycles flip the lines so a stale value never looks valid
    always @(posedge clk_i) begin
        bus_valid_o <= req_i;
        bus_addr_o <= req_i ? addr_i : ~bus_addr_o;
        bus_data_o <= req_i ? data_i : ~bus_data_o;
        bus_rw_o <= req_i ? rw_i : ~bus_rw_o;
        if (brk_req_i === 1'b1) begin
            n_brk_o <= n_brk_o + 8'h01;
        end
        if (tag_req_i === 1'b1) begin
            n_tag_o <= n_tag_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== sim/btc_top_tb_top.sv
// Register-driven testbench for the bus trigger comparator
`default_nettype none
module btc_top_tb_top
    import btc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'hf;
    logic [31:0] rdat;
    logic ack, req, q_rw, valid, rw, trig, brk, tag;
    logic [15:0] q_addr, baddr;
    logic [7:0] q_data, bdata, n_brk, n_tag;
    int n_fail = 0;
    int compares = 0;
    int n_trig = 0;
    initial begin
        req = 1'b0;
        q_rw = 1'b0;
        q_addr = 16'h0000;
        q_data = 8'h00;
        forever #50 clk = ~clk;
    end
    btc_top u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bus_valid_i(valid),
        .bus_addr_i(baddr), .bus_data_i(bdata), .bus_rw_i(rw),
        .trigger_o(trig), .brk_req_o(brk), .tag_req_o(tag));
    btc_cpu_model u_cpu (.clk_i(clk), .req_i(req), .addr_i(q_addr),
        .data_i(q_data), .rw_i(q_rw), .brk_req_i(brk), .tag_req_i(tag),
        .bus_valid_o(valid), .bus_addr_o(baddr), .bus_data_o(bdata),
        .bus_rw_o(rw), .n_brk_o(n_brk), .n_tag_o(n_tag));
    always @(posedge clk) begin
        if (trig === 1'b1) begin
            n_trig <= n_trig + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (ack !== 1'b1) begin
            n_fail++;
            $display("MISMATCH wb_ack_o expected 1 seen %b", ack);
            close_out();
        end else begin
            q = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk("read_data", e, q);
    endtask
    // Arm is cleared first so every set-up that sets arm restarts capture and A-seen
    task automatic setup(input logic [3:0] m, input logic [7:0] f,
                         input logic [15:0] a, input logic [15:0] b);
        logic [31:0] q;
        wb(1'b1, OFS_CMPA, {16'h0000, a}, q);
        wb(1'b1, OFS_CMPB, {16'h0000, b}, q);
        wb(1'b1, OFS_CTRL, {20'h0_0000, m, f & 8'hfe}, q);
        wb(1'b1, OFS_CTRL, {20'h0_0000, m, f}, q);
    endtask
    // Four back-to-back bus cycles, first address in the top bits
    task automatic walk(input logic [63:0] al, input logic [7:0] d,
                        input logic r, input int e);
        int t;
        t = n_trig;
        for (int i = 3; i >= 0; i--) begin
            @(posedge clk);
            req <= 1'b1;
            q_addr <= al[16*i+:16];
            q_data <= d;
            q_rw <= r;
        end
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(negedge clk);
        if (e >= 0) begin
            chk("trigger_count", e, n_trig - t);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [7:0] b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rchk(OFS_CTRL, RST_WORD);
        rchk(OFS_STAT, 32'h0000_0008);
        wb(1'b1, 8'h20, 32'hffff_ffff, q);
        rchk(8'h20, 32'h0000_0000);
        sel <= 4'h1;
        wb(1'b1, OFS_CMPA, 32'h0000_ab99, q);
        sel <= 4'hf;
        rchk(OFS_CMPA, 32'h0000_0099);
        setup(MODE_A_ONLY, 8'h01, 16'h1234, 16'h5678);
        rchk(OFS_CMPA, 32'h0000_1234);
        walk(64'h1234_5678_1235_1234, 8'h00, 1'b0, 2);
        setup(MODE_A_OR_B, 8'h01, 16'h1234, 16'h5678);
        walk(64'h1234_5678_0000_5679, 8'h00, 1'b0, 2);
        setup(MODE_A_THEN_B, 8'h01, 16'h1234, 16'h5678);
        walk(64'h5678_1234_5678_5678, 8'h00, 1'b0, 2);
        setup(MODE_A_AND_D, 8'h07, 16'h1234, 16'hff42);
        walk(64'h1234_1234_1235_1234, 8'h42, 1'b1, 3);
        walk(64'h1234_1234_1234_1234, 8'h42, 1'b0, 0);
        walk(64'h1234_1234_1234_1234, 8'h43, 1'b1, 0);
        setup(MODE_A_NOT_D, 8'h05, 16'h1234, 16'hff42);
        walk(64'h1234_1234_1235_1234, 8'h43, 1'b0, 3);
        walk(64'h1234_1234_1234_1234, 8'h42, 1'b0, 0);
        walk(64'h1234_1234_1234_1234, 8'h43, 1'b1, 0);
        setup(MODE_A_AND_D, 8'h19, 16'h1234, 16'hff42);
        b0 = n_tag;
        walk(64'h1234_1234_1235_0000, 8'h43, 1'b0, -1);
        chk("tag_count", 32'h0000_0002, {24'h00_0000, n_tag - b0});
        setup(MODE_A_ONLY, 8'h09, 16'h1234, 16'h5678);
        b0 = n_brk;
        walk(64'h1234_0000_1234_0001, 8'h00, 1'b0, 2);
        chk("brk_count", 32'h0000_0002, {24'h00_0000, n_brk - b0});
        setup(MODE_IN_RANGE, 8'h01, 16'h0100, 16'h0200);
        walk(64'h00ff_0100_0200_0201, 8'h00, 1'b0, 2);
        setup(MODE_OUT_RANGE, 8'h01, 16'h0100, 16'h0200);
        walk(64'h00ff_0100_0200_0201, 8'h00, 1'b0, 2);
        setup(MODE_A_ONLY, 8'h00, 16'h1234, 16'h5678);
        walk(64'h1234_1234_1234_1234, 8'h00, 1'b0, 0);
        setup(4'h9, 8'h01, 16'h1234, 16'h5678);
        walk(64'h1234_5678_1234_5678, 8'h00, 1'b0, 0);
        setup(MODE_EVT_B, 8'h01, 16'h1234, 16'h5678);
        for (int i = 0; i < 9; i++) begin
            walk(64'h5678_0000_0000_0000, 8'h10 + 8'(i), 1'b0,
                 int'(i < 8));
        end
        rchk(OFS_STAT, 32'h0000_0814);
        for (int i = 0; i < 8; i++) begin
            rchk(OFS_FIFO, 32'h0000_0010 + 32'(i));
        end
        rchk(OFS_STAT, 32'h0000_0018);
        setup(MODE_A_THEN_EVT_B, 8'h01, 16'h1234, 16'h5678);
        walk(64'h5678_1234_5678_0000, 8'h55, 1'b0, 1);
        rchk(OFS_STAT, 32'h0000_0113);
        rchk(OFS_FIFO, 32'h0000_0055);
        close_out();
    end
endmodule
`default_nettype wire
